/* File: idx_exec.sv */
// Executor for skip, increment, inclusive OR and branch instructions
`timescale 1ns/1ps
module idx_exec (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire idx_pkg::idx_instr_t instr,
    input  wire logic [7:0]          file_rdata,
    input  wire logic [7:0]          upper_address_latch,
    output logic [14:0]              program_counter,
    output logic                     pc_load,
    output logic                     squash,
    output logic                     busy,
    output idx_pkg::idx_fwr_t        file_wr,
    output logic [7:0]               acc,
    output logic                     zero_flag
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic srst_n = rst_s2_reg;

    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction : is_zero

    // ------------------------------------------------------------
    // Execution state
    // ------------------------------------------------------------
    idx_pkg::idx_state_t state_reg, state_next;
    logic [7:0]          acc_reg, acc_next;
    logic                z_reg, z_next;
    logic [14:0]         pc_reg, pc_next;
    logic                pcl_reg, pcl_next;
    idx_pkg::idx_fwr_t   fwr_reg, fwr_next;
    logic [7:0]          res;
    logic                take;

    assign take = instr.valid && (state_reg == idx_pkg::IDX_ST_EXEC);

    always_comb begin
        state_next = idx_pkg::IDX_ST_EXEC;
        acc_next   = acc_reg;
        z_next     = z_reg;
        pc_next    = pc_reg;
        pcl_next   = 1'b0;
        fwr_next   = '0;
        res        = 8'h00;
        if (take) begin
            case (instr.op)
                idx_pkg::IDX_OP_DECSZ: res = file_rdata - idx_pkg::IDX_ONE;
                idx_pkg::IDX_OP_INCSZ,
                idx_pkg::IDX_OP_INC:   res = file_rdata + idx_pkg::IDX_ONE;
                idx_pkg::IDX_OP_IORL:  res = acc_reg | instr.lit[7:0];
                idx_pkg::IDX_OP_IORF:  res = acc_reg | file_rdata;
                default:               res = 8'h00;
            endcase
            case (instr.op)
                idx_pkg::IDX_OP_DECSZ, idx_pkg::IDX_OP_INCSZ,
                idx_pkg::IDX_OP_INC, idx_pkg::IDX_OP_IORF: begin
                    if (instr.dest) begin
                        fwr_next = '{we: 1'b1, addr: instr.faddr, data: res};
                    end else begin
                        acc_next = res;
                    end
                end
                idx_pkg::IDX_OP_IORL: begin
                    acc_next = res;
                end
                default: begin
                end
            endcase
            case (instr.op)
                idx_pkg::IDX_OP_INC, idx_pkg::IDX_OP_IORF,
                idx_pkg::IDX_OP_IORL: begin
                    z_next = is_zero(res);
                end
                idx_pkg::IDX_OP_DECSZ, idx_pkg::IDX_OP_INCSZ: begin
                    if (is_zero(res)) begin
                        state_next = idx_pkg::IDX_ST_SKIP;
                    end
                end
                idx_pkg::IDX_OP_BRA: begin
                    pc_next = {upper_address_latch[idx_pkg::IDX_LATCH_HI:idx_pkg::IDX_LATCH_LO],
                               instr.lit};
                    pcl_next   = 1'b1;
                    state_next = idx_pkg::IDX_ST_BRA;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            state_reg <= idx_pkg::IDX_ST_EXEC;
            acc_reg   <= idx_pkg::IDX_ACC_RST;
            z_reg     <= 1'b0;
            pc_reg    <= idx_pkg::IDX_PC_RST;
            pcl_reg   <= 1'b0;
            fwr_reg   <= '0;
        end else begin
            state_reg <= state_next;
            acc_reg   <= acc_next;
            z_reg     <= z_next;
            pc_reg    <= pc_next;
            pcl_reg   <= pcl_next;
            fwr_reg   <= fwr_next;
        end
    end

    // Second cycle ignores the fetched word: it is the squashed slot
    assign squash          = (state_reg != idx_pkg::IDX_ST_EXEC);
    assign busy            = squash;
    assign program_counter = pc_reg;
    assign pc_load         = pcl_reg;
    assign file_wr         = fwr_reg;
    assign acc             = acc_reg;
    assign zero_flag       = z_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_skip_start;
        take && (instr.op inside {idx_pkg::IDX_OP_DECSZ, idx_pkg::IDX_OP_INCSZ})
             && is_zero(res);
    endsequence

    dec_result_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_DECSZ && !instr.dest
        |=> acc == $past(file_rdata) - 8'h01)
        else $error("decrement result wrong");
    skip_zero_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        s_skip_start |=> squash ##1 !squash)
        else $error("skip slot missing");
    incsz_noflag_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_INCSZ |=> $stable(zero_flag))
        else $error("increment-skip touched flag");
    bra_pc_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_BRA
        |=> pc_load && program_counter == {$past(upper_address_latch[6:3]), $past(instr.lit)})
        else $error("branch target wrong");
    bra_two_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_BRA |=> squash && $stable(zero_flag))
        else $error("branch not two cycles");
    iorl_acc_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_IORL
        |=> acc == ($past(acc) | $past(instr.lit[7:0])))
        else $error("or literal wrong");
    inc_file_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_INC && instr.dest
        |=> file_wr.we && file_wr.data == $past(file_rdata) + 8'h01)
        else $error("increment write wrong");
    iorf_acc_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_IORF && !instr.dest
        |=> acc == ($past(acc) | $past(file_rdata)))
        else $error("or file wrong");
    zflag_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op inside {idx_pkg::IDX_OP_INC, idx_pkg::IDX_OP_IORF,
                                 idx_pkg::IDX_OP_IORL}
        |=> zero_flag == ($past(res) == 8'h00))
        else $error("zero flag wrong");

    // ------------------------------------------------------------
    // Further next-cycle checks and the branch slot sequence
    // ------------------------------------------------------------
    sequence s_branch_start;
        take && instr.op == idx_pkg::IDX_OP_BRA;
    endsequence

    sequence s_two_slot;
        squash ##1 !squash;
    endsequence

    sequence s_plain_run;
        take && (instr.op inside {idx_pkg::IDX_OP_DECSZ, idx_pkg::IDX_OP_INCSZ})
             && !is_zero(res);
    endsequence

    dec_noflag_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_DECSZ |=> $stable(zero_flag))
        else $error("decrement-skip touched flag");
    dec_file_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_DECSZ && instr.dest
        |=> file_wr.we && file_wr.data == $past(file_rdata) - 8'h01 && $stable(acc))
        else $error("decrement write wrong");
    skip_none_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        s_plain_run |=> !squash)
        else $error("skip taken on nonzero result");
    squash_idle_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        squash |=> !pc_load && !file_wr.we && $stable(acc) && $stable(zero_flag))
        else $error("squashed slot had effect");
    incsz_file_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_INCSZ && instr.dest
        |=> file_wr.we && file_wr.data == $past(file_rdata) + 8'h01)
        else $error("increment-skip write wrong");
    pc_hold_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        !(take && instr.op == idx_pkg::IDX_OP_BRA) |=> $stable(program_counter) && !pc_load)
        else $error("counter moved without branch");
    bra_slot_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        s_branch_start |=> s_two_slot)
        else $error("branch slot count wrong");
    bra_hold_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        s_branch_start |=> $stable(acc) && !file_wr.we)
        else $error("branch touched data");
    inc_acc_a: assert property (@(posedge ref_clk) disable iff (!srst_n)
        take && instr.op == idx_pkg::IDX_OP_INC && !instr.dest
        |=> acc == $past(file_rdata) + 8'h01 && !file_wr.we)
        else $error("increment accumulator wrong");

endmodule : idx_exec

/* File: idx_pkg.sv */
// Package of constants and carrier types for the partial instruction executor
package idx_pkg;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IDX_OP_NONE  = 3'h0,
        IDX_OP_DECSZ = 3'h1,
        IDX_OP_INCSZ = 3'h2,
        IDX_OP_BRA   = 3'h3,
        IDX_OP_IORL  = 3'h4,
        IDX_OP_INC   = 3'h5,
        IDX_OP_IORF  = 3'h6
    } idx_op_t;

    typedef enum logic [1:0] {
        IDX_ST_EXEC = 2'h0,
        IDX_ST_SKIP = 2'h1,
        IDX_ST_BRA  = 2'h3
    } idx_state_t;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          IDX_LIT_W      = 11;
    localparam int          IDX_PC_W       = 15;
    localparam int          IDX_LATCH_LO   = 3;
    localparam int          IDX_LATCH_HI   = 6;
    localparam logic [7:0]  IDX_ACC_RST    = 8'h00;
    localparam logic [14:0] IDX_PC_RST     = 15'h0000;
    localparam logic [7:0]  IDX_ONE        = 8'h01;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        idx_op_t     op;
        logic        dest;
        logic [6:0]  faddr;
        logic [10:0] lit;
    } idx_instr_t;

    typedef struct packed {
        logic        we;
        logic [6:0]  addr;
        logic [7:0]  data;
    } idx_fwr_t;

endpackage : idx_pkg

/* File: idx_file_model.sv */
// Behavioural data memory file that answers the executor's reads and writes
`timescale 1ns/1ps
module idx_file_model (
    input  wire logic              ref_clk,
    input  wire logic [6:0]        faddr,
    input  wire idx_pkg::idx_fwr_t file_wr,
    output logic [7:0]             file_rdata
);
    // ------------------------------------------------------------
    // Storage, combinational read, write on strobe
    // ------------------------------------------------------------
    logic [7:0] mem [128];

    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i);
        end
    end

    // Pending write lands on the edge that takes the next read, so forward it
    assign file_rdata = (file_wr.we && file_wr.addr == faddr) ? file_wr.data : mem[faddr];

    always @(posedge ref_clk) begin
        if (file_wr.we) begin
            mem[file_wr.addr] <= file_wr.data;
        end
    end
endmodule : idx_file_model

/* File: tb_inc_dec_skip_branch_or_exec.sv */
// Self-checking bench for the partial instruction executor
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH %0t %s", $time, m); end end
module tb_inc_dec_skip_branch_or_exec;
    logic                ref_clk = 1'b0;
    logic                rst_n   = 1'b0;
    idx_pkg::idx_instr_t instr   = '0;
    logic [7:0]          latch   = 8'h00;
    logic [7:0]          file_rdata, acc, acc_m;
    logic [7:0]          mem_m [128];
    logic [14:0]         program_counter;
    logic                pc_load, squash, busy, zero_flag, zf_m;
    idx_pkg::idx_fwr_t   file_wr;
    logic [31:0]         seed = 32'h91525308;
    int                  bad_count = 0;
    int                  check_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    idx_exec dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .file_rdata(file_rdata),
        .upper_address_latch(latch), .program_counter(program_counter), .pc_load(pc_load),
        .squash(squash), .busy(busy), .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag));
    idx_file_model mem (.ref_clk(ref_clk), .faddr(instr.faddr), .file_wr(file_wr),
        .file_rdata(file_rdata));

    // ------------------------------------------------------------
    // Expectations and random source
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_result(input logic [2:0] op, input logic [7:0] a,
                                              input logic [7:0] f, input logic [7:0] k);
        case (op)
            3'h1:       return f - 8'h01;
            3'h2, 3'h5: return f + 8'h01;
            3'h4:       return a | k;
            3'h6:       return a | f;
            default:    return 8'h00;
        endcase
    endfunction : exp_result

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // ------------------------------------------------------------
    // One instruction, expectation worked out beforehand
    // ------------------------------------------------------------
    task automatic step(input logic [2:0] op, input logic dest, input logic [6:0] fa,
                        input logic [10:0] lit, input logic vld);
        logic [7:0] r;
        logic act, wr, skip;
        r    = exp_result(op, acc_m, mem_m[fa], lit[7:0]);
        act  = vld && op != 3'h0 && op != 3'h3;
        wr   = act && dest && op != 3'h4;
        skip = vld && (op == 3'h3 || ((op == 3'h1 || op == 3'h2) && r == 8'h00));
        instr = '{vld, idx_pkg::idx_op_t'(op), dest, fa, lit};
        @(negedge ref_clk);
        if (act && !wr) acc_m = r;
        if (wr) mem_m[fa] = r;
        if (vld && op >= 3'h4) zf_m = (r == 8'h00);
        `CHK(acc, acc_m, "accumulator")
        `CHK(zero_flag, zf_m, "zero flag")
        `CHK(file_wr.we, wr, "write strobe")
        if (wr) `CHK({file_wr.addr, file_wr.data}, {fa, r}, "write")
        `CHK(squash, skip, "skip cycle")
        `CHK(busy, skip, "busy")
        `CHK(pc_load, vld && op == 3'h3, "branch load")
        if (vld && op == 3'h3) `CHK(program_counter, {latch[6:3], lit}, "target")
        if (skip) begin
            // Offered while squashed, so it must leave no trace
            instr = '{1'b1, idx_pkg::IDX_OP_IORL, 1'b1, fa, 11'h7FF};
            @(negedge ref_clk);
            `CHK({file_wr.we, squash, acc}, {2'b00, acc_m}, "ignored")
        end
    endtask : step

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) mem_m[i] = 8'(i);
        acc_m = 8'h00;
        zf_m  = 1'b0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK({acc, zero_flag, pc_load, squash}, 11'h000, "reset state")
        step(3'h1, 1'b1, 7'h01, 11'h000, 1'b1);
        step(3'h1, 1'b0, 7'h02, 11'h000, 1'b1);
        step(3'h4, 1'b0, 7'h00, 11'h0FF, 1'b1);
        step(3'h6, 1'b1, 7'h00, 11'h000, 1'b1);
        step(3'h2, 1'b0, 7'h00, 11'h000, 1'b1);
        step(3'h5, 1'b1, 7'h00, 11'h000, 1'b1);
        latch = 8'h78;
        step(3'h3, 1'b0, 7'h00, 11'h7FF, 1'b1);
        latch = 8'h87;
        step(3'h3, 1'b0, 7'h00, 11'h000, 1'b1);
        for (int n = 0; n < 300; n++) begin
            seed  = xorshift(seed);
            latch = seed[31:24];
            step(3'(seed[2:0] % 3'h7), seed[3], seed[10:4], seed[21:11], seed[22] | seed[23]);
        end
        summarize();
    end

    initial begin
        // Worst case is two cycles per instruction, so this leaves ample margin
        #(25 * 5000);
        bad_count++;
        summarize();
    end
endmodule : tb_inc_dec_skip_branch_or_exec
